// ===== design/dxyds_agu.sv
/*
  Address generation unit: post-modifies an effective address by a signed
  step, wrapping inside a modulo buffer, or steps it bit-reversed.
  Assumes the caller enables bit-reversal only where it is allowed.
*/
`timescale 1ns/1ps
module dxyds_agu
  import dxyds_pkg::*;
(
  input  wire logic [15:0] ea,
  input  wire logic [15:0] step,
  input  wire logic        mod_en,
  input  wire logic [15:0] mod_start,
  input  wire logic [15:0] mod_end,
  input  wire logic        brev_en,
  input  wire logic [15:0] brev_mod,
  output logic      [15:0] next_ea
);

  // Reverse the word-index bits of an address
  function automatic logic [14:0] rev15(input logic [14:0] v);
    logic [14:0] r;
    r = '0;
    for (int i = 0; i < 15; i++) begin
      r[i] = v[14-i];
    end
    return r;
  endfunction

  logic [15:0] lin;
  logic [14:0] rsum;

  ////////////////////////////////////////////////////////////////////////
  // Linear step, modulo wrap, or reverse-carry step
  always_comb begin
    lin     = 16'(ea + step);
    rsum    = 15'(rev15(ea[15:1]) + rev15(brev_mod[15:1]));
    next_ea = lin;
    if (brev_en) begin
      next_ea = {rev15(rsum), ea[0]};
    end else if (mod_en && !step[15] && step != 16'h0000 &&
                 lin > mod_end) begin
      next_ea = 16'(mod_start + (lin - mod_end) - 16'h0001);
    end else if (mod_en && step[15] && lin < mod_start) begin
      next_ea = 16'(mod_end - (mod_start - lin) + 16'h0001);
    end
  end

endmodule // dxyds_agu

// ===== design/dxyds_core.sv
/*
  Dual X/Y data-space access block of a 16-bit DSP core: core registers,
  data RAM, X read/write paths, Y read path, three address generators and
  an APB slave for software access to the registers.
  Assumes the execution unit drives requests synchronous to mclk and an
  APB master with 32-bit data; one clock, asynchronous active-high reset.
*/
// The APB slave port was left to the implementer.
// Summary of operation
// - X and Y spaces each have their own address generator and data path.
// - A multiply-accumulate class op reads one X word and one Y word at once.
// - Every instruction may use X space with any addressing mode except bit-reversed reads.
// - X space has separate read and write buses.
// - The X read bus serves combined-space reads and the X operand prefetch.
// - The Y read path serves only multiply-accumulate class ops.
// - Both X and Y address generators support modulo addressing.
// - Bit-reversed stepping applies only to X writes, never Y or reads.
// - All writes decode against the single combined X plus Y range.
// - The X/Y boundary is a fixed constant that software cannot move.
// - Effective addresses are 16-bit byte addresses over 64 Kbytes.
// - Sixteen working registers map from address 0; the stack pointer resets to 0x0800.
// - The stack limit register sits at 0x0020 with undefined reset content.
// - Unused special function register addresses read as zero.
`timescale 1ns/1ps
module dxyds_core
  import dxyds_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mac_op,
  input  wire logic        x_rd_en,
  input  wire logic [15:0] x_rd_ea,
  input  wire logic        x_rd_byte,
  input  wire logic [15:0] x_rd_step,
  input  wire logic        y_rd_en,
  input  wire logic [15:0] y_rd_ea,
  input  wire logic [15:0] y_rd_step,
  input  wire logic        x_wr_en,
  input  wire logic [15:0] x_wr_ea,
  input  wire logic        x_wr_byte,
  input  wire logic [15:0] x_wr_data,
  input  wire logic [15:0] x_wr_step,
  input  wire logic        x_wr_brev,
  output logic      [15:0] x_rd_data,
  output logic             x_rd_valid,
  output logic      [15:0] y_rd_data,
  output logic             y_rd_valid,
  output logic      [15:0] x_rd_next,
  output logic      [15:0] y_rd_next,
  output logic      [15:0] x_wr_next,
  output logic             addr_err
);

  dxyds_state_s q;
  dxyds_state_s d;

  logic [15:0] ram [RAM_WORDS];
  logic        ram_we;
  logic [9:0]  ram_widx;
  logic [15:0] ram_wdata;

  logic [2:0][15:0] agu_ea;
  logic [2:0][15:0] agu_step;
  logic [2:0]       agu_mod;
  logic [2:0][15:0] agu_ms;
  logic [2:0][15:0] agu_me;
  logic [2:0]       agu_brev;
  logic [2:0][15:0] agu_next;

  ////////////////////////////////////////////////////////////////////////
  // Decode functions

  // Map a data-space byte address onto core registers or RAM
  function automatic dxyds_dec_s ds_decode(input logic [15:0] ea);
    dxyds_dec_s r;
    r.kind = DS_NONE;
    r.idx  = '0;
    if (ea < CORE_END) begin
      r.kind = DS_CORE;
      r.idx  = {5'h00, ea[5:1]};
    end else if (ea >= RAM_BASE && ea <= RAM_LAST) begin
      r.kind = DS_RAM;
      r.idx  = ea[10:1];
    end
    return r;
  endfunction

  // Find the register slot behind an APB index
  function automatic logic [5:0] apb_slot(input logic [15:0] idx);
    logic [5:0] r;
    r = 6'h3f;
    for (int i = 0; i < NREG; i++) begin
      if (REG_OFS[i] == idx) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // Merge a byte or word write into an old word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic        is_byte,
                                        input logic        hi);
    logic [15:0] r;
    r = wd;
    if (is_byte && hi) begin
      r = {wd[7:0], old[7:0]};
    end else if (is_byte) begin
      r = {old[15:8], wd[7:0]};
    end
    return r;
  endfunction

  // Select the addressed byte onto the low lane
  function automatic logic [15:0] lane(input logic [15:0] w,
                                       input logic        is_byte,
                                       input logic        hi);
    logic [15:0] r;
    r = w;
    if (is_byte) begin
      r = {8'h00, hi ? w[15:8] : w[7:0]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Address generators: 0 = X read, 1 = Y read, 2 = X write
  always_comb begin
    agu_ea   = {x_wr_ea, y_rd_ea, x_rd_ea};
    agu_step = {x_wr_step, y_rd_step, x_rd_step};
    agu_mod  = {q.cfg[CFG_XMOD], q.cfg[CFG_YMOD], q.cfg[CFG_XMOD]};
    agu_ms   = {q.xms, q.yms, q.xms};
    agu_me   = {q.xme, q.yme, q.xme};
    agu_brev = {q.cfg[CFG_BREV] & x_wr_brev, 2'b00};
  end

  // One unit per path so X and Y never share address logic
  for (genvar g = 0; g < 3; g++) begin : g_agu
    dxyds_agu u_agu (
      .ea        (agu_ea[g]),
      .step      (agu_step[g]),
      .mod_en    (agu_mod[g]),
      .mod_start (agu_ms[g]),
      .mod_end   (agu_me[g]),
      .brev_en   (agu_brev[g]),
      .brev_mod  (q.bmod),
      .next_ea   (agu_next[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    dxyds_dec_s  xr;
    dxyds_dec_s  yr;
    dxyds_dec_s  xw;
    logic [15:0] idx;
    logic [5:0]  slot;
    logic [15:0] word;
    logic        apb_set;
    logic        apb_wr;
    xr        = ds_decode(x_rd_ea);
    yr        = ds_decode(y_rd_ea);
    xw        = ds_decode(x_wr_ea);
    idx       = paddr[17:2];
    slot      = apb_slot(idx);
    word      = '0;
    apb_set   = psel && !penable;
    apb_wr    = psel && penable && pwrite;
    ram_we    = 1'b0;
    ram_widx  = xw.idx;
    ram_wdata = '0;
    d         = q;
    d.x_rd_valid = 1'b0;
    d.y_rd_valid = 1'b0;
    d.addr_err   = 1'b0;

    // APB read data is captured in the setup phase
    if (apb_set) begin
      d.pslverr = 1'b0;
      d.prdata  = '0;
      if (slot != 6'h3f) begin
        d.prdata = {16'h0000, q.regs[slot]};
      end else begin
        unique case (idx)
          OFS_CFG:  d.prdata = {29'h0, q.cfg};
          OFS_XMS:  d.prdata = {16'h0000, q.xms};
          OFS_XME:  d.prdata = {16'h0000, q.xme};
          OFS_YMS:  d.prdata = {16'h0000, q.yms};
          OFS_YME:  d.prdata = {16'h0000, q.yme};
          OFS_BMOD: d.prdata = {16'h0000, q.bmod};
          OFS_STAT: d.prdata = {q.y_rd_next, q.x_rd_next};
          default:  d.pslverr = 1'b1;
        endcase
      end
      if (pwrite && idx == OFS_STAT) begin
        d.pslverr = 1'b1;                             // Status is read-only
      end
    end

    // APB write in the access phase
    if (apb_wr && !q.pslverr) begin
      if (slot != 6'h3f) begin
        d.regs[slot] = pwdata[15:0];
      end else begin
        unique case (idx)
          OFS_CFG:  d.cfg  = pwdata[2:0];
          OFS_XMS:  d.xms  = pwdata[15:0];
          OFS_XME:  d.xme  = pwdata[15:0];
          OFS_YMS:  d.yms  = pwdata[15:0];
          OFS_YME:  d.yme  = pwdata[15:0];
          OFS_BMOD: d.bmod = pwdata[15:0];
          default:  d.cfg  = q.cfg;
        endcase
      end
    end

    // X read: any instruction, combined space, also MAC X prefetch
    if (x_rd_en) begin
      word = '0;
      if (xr.kind == DS_CORE) begin
        word = q.regs[xr.idx[4:0]];
      end else if (xr.kind == DS_RAM) begin
        word = ram[xr.idx];
      end
      d.x_rd_data  = lane(word, x_rd_byte, x_rd_ea[0]);
      d.x_rd_valid = 1'b1;
      d.x_rd_next  = agu_next[0];
      if (!x_rd_byte && x_rd_ea[0]) begin
        d.addr_err = 1'b1;                            // Read completes
      end
    end

    // Y read: MAC class only, same cycle as X, Y region only
    if (y_rd_en && mac_op) begin
      d.y_rd_data = '0;
      if (yr.kind == DS_RAM && y_rd_ea >= Y_BASE) begin
        d.y_rd_data = ram[yr.idx];
      end
      d.y_rd_valid = 1'b1;
      d.y_rd_next  = agu_next[1];
      if (y_rd_ea[0]) begin
        d.addr_err = 1'b1;
      end
    end

    // X write bus: combined space, misaligned word writes dropped
    if (x_wr_en) begin
      d.x_wr_next = agu_next[2];
      if (!x_wr_byte && x_wr_ea[0]) begin
        d.addr_err = 1'b1;
      end else if (xw.kind == DS_CORE) begin
        d.regs[xw.idx[4:0]] = merge(q.regs[xw.idx[4:0]], x_wr_data,
                                    x_wr_byte, x_wr_ea[0]);
      end else if (xw.kind == DS_RAM) begin
        ram_we    = 1'b1;
        ram_wdata = merge(ram[xw.idx], x_wr_data, x_wr_byte, x_wr_ea[0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Data RAM, no reset
  always_ff @(posedge mclk) begin
    if (ram_we) begin
      ram[ram_widx] <= ram_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata     = q.prdata;
  assign pready     = 1'b1;                           // No wait states
  assign pslverr    = psel & penable & q.pslverr;
  assign x_rd_data  = q.x_rd_data;
  assign x_rd_valid = q.x_rd_valid;
  assign y_rd_data  = q.y_rd_data;
  assign y_rd_valid = q.y_rd_valid;
  assign x_rd_next  = q.x_rd_next;
  assign y_rd_next  = q.y_rd_next;
  assign x_wr_next  = q.x_wr_next;
  assign addr_err   = q.addr_err;

endmodule // dxyds_core

// ===== design/dxyds_pkg.sv
/*
  Package for the dual X/Y data-space block: register slots, printed
  offsets, reset values, data-space regions, own control offsets and the
  state record of the main module.
  Assumes a single core clock and an APB master for software access.
*/
package dxyds_pkg;

  // Register slots, slot n sits at data-space byte address 2*n
  localparam int NREG       = 24;
  localparam int SLOT_SP    = 15;
  localparam int SLOT_LIMIT = 16;

  // Printed offsets, kept as APB register indices (byte address = 4*index)
  localparam logic [NREG-1:0][15:0] REG_OFS = '{
    16'h002e, 16'h002c, 16'h002a, 16'h0028, 16'h0026, 16'h0024,
    16'h0022, 16'h0020, 16'h001e, 16'h001c, 16'h001a, 16'h0018,
    16'h0016, 16'h0014, 16'h0012, 16'h0010, 16'h000e, 16'h000c,
    16'h000a, 16'h8000, 16'h0006, 16'h0004, 16'h0002, 16'h0000};

  // Reset values; the stack limit is undefined and modelled as zero
  localparam logic [15:0] SP_RST    = 16'h0800;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [NREG-1:0][15:0] REG_RST =
    {{(NREG-SLOT_LIMIT-1){16'h0000}}, LIMIT_RST, SP_RST,
     {SLOT_SP{16'h0000}}};

  // Data-space map: 16-bit byte addresses, 64 Kbyte range
  localparam logic [15:0] SFR_END    = 16'h0800;
  localparam logic [15:0] CORE_END   = 16'h0030;
  localparam logic [15:0] RAM_BASE   = 16'h0800;
  localparam logic [15:0] RAM_LAST   = 16'h0fff;
  localparam logic [15:0] Y_BASE     = 16'h0c00;
  localparam int          RAM_WORDS  = 1024;

  // Own control registers, APB indices
  localparam logic [15:0] OFS_CFG    = 16'h0100;
  localparam logic [15:0] OFS_XMS    = 16'h0101;
  localparam logic [15:0] OFS_XME    = 16'h0102;
  localparam logic [15:0] OFS_YMS    = 16'h0103;
  localparam logic [15:0] OFS_YME    = 16'h0104;
  localparam logic [15:0] OFS_BMOD   = 16'h0105;
  localparam logic [15:0] OFS_STAT   = 16'h0106;

  // Control bit positions
  localparam int CFG_XMOD = 0;
  localparam int CFG_YMOD = 1;
  localparam int CFG_BREV = 2;

  // Data-space decode result
  typedef enum logic [1:0] {DS_NONE, DS_CORE, DS_RAM} dxyds_kind_e;

  typedef struct packed {
    dxyds_kind_e kind;
    logic [9:0]  idx;
  } dxyds_dec_s;

  // State of the main module apart from the data RAM
  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    logic [2:0]            cfg;
    logic [15:0]           xms;
    logic [15:0]           xme;
    logic [15:0]           yms;
    logic [15:0]           yme;
    logic [15:0]           bmod;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic [15:0]           x_rd_data;
    logic [15:0]           y_rd_data;
    logic                  x_rd_valid;
    logic                  y_rd_valid;
    logic                  addr_err;
    logic [15:0]           x_rd_next;
    logic [15:0]           y_rd_next;
    logic [15:0]           x_wr_next;
  } dxyds_state_s;

  localparam dxyds_state_s STATE_RST = '{regs: REG_RST, default: '0};

endpackage

// ===== tb/dxyds_core_props.sv
/*
  Checker for core request/answer timing of the data-space block.
  Assumes it is bound to dxyds_core and sees its ports only.
*/
`timescale 1ns/1ps
module dxyds_core_props
  import dxyds_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        mac_op,
  input wire logic        x_rd_en,
  input wire logic        x_rd_byte,
  input wire logic [15:0] x_rd_ea,
  input wire logic        y_rd_en,
  input wire logic [15:0] y_rd_ea,
  input wire logic        x_wr_en,
  input wire logic        x_wr_byte,
  input wire logic [15:0] x_wr_ea,
  input wire logic [15:0] x_rd_data,
  input wire logic        x_rd_valid,
  input wire logic        y_rd_valid,
  input wire logic        addr_err
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Any odd word address on a request
  wire odd_w = (x_rd_en && !x_rd_byte && x_rd_ea[0]) ||
               (x_wr_en && !x_wr_byte && x_wr_ea[0]) ||
               (y_rd_en && mac_op && y_rd_ea[0]);
  sequence s_dual_req; x_rd_en && y_rd_en && mac_op; endsequence
  sequence s_dual_ans; x_rd_valid && y_rd_valid; endsequence
  property p_x_ans; x_rd_en |=> x_rd_valid; endproperty
  property p_x_idle; !x_rd_en |=> !x_rd_valid; endproperty
  property p_y_ans; y_rd_en && mac_op |=> y_rd_valid; endproperty
  property p_y_mac; !(y_rd_en && mac_op) |=> !y_rd_valid; endproperty
  property p_dual; s_dual_req |=> s_dual_ans; endproperty
  property p_err; odd_w |=> addr_err; endproperty
  property p_no_err; !odd_w |=> !addr_err; endproperty
  property p_hold; !x_rd_en |=> $stable(x_rd_data); endproperty
  a_x_ans: assert property (p_x_ans)
    else $error("x read answer missing");
  a_x_idle: assert property (p_x_idle)
    else $error("x read answer without request");
  a_y_ans: assert property (p_y_ans)
    else $error("y read answer missing");
  a_y_mac: assert property (p_y_mac)
    else $error("y read answer outside multiply class");
  a_dual: assert property (p_dual)
    else $error("dual read not answered together");
  a_err: assert property (p_err)
    else $error("odd word access not flagged");
  a_no_err: assert property (p_no_err)
    else $error("address error without cause");
  a_hold: assert property (p_hold)
    else $error("x read data changed without request");
endmodule // dxyds_core_props

bind dxyds_core dxyds_core_props u_dxyds_core_props (
  .mclk, .reset, .mac_op, .x_rd_en, .x_rd_byte, .x_rd_ea, .y_rd_en,
  .y_rd_ea, .x_wr_en, .x_wr_byte, .x_wr_ea, .x_rd_data, .x_rd_valid,
  .y_rd_valid, .addr_err
);

// ===== tb/dxyds_core_tb_top.sv
/*
  Bench for the dual X/Y data-space block: APB master, word model of
  registers and RAM, execution unit model.
  Assumes zero-wait APB and one-cycle core read answers.
*/
`timescale 1ns/1ps
module dxyds_core_tb_top
  import dxyds_pkg::*;
;
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        mac_op, x_rd_en, y_rd_en, x_wr_en, x_rd_byte, x_wr_byte;
  logic        x_wr_brev, x_rd_valid, y_rd_valid, addr_err;
  logic [15:0] x_rd_ea, y_rd_ea, x_wr_ea, x_wr_data, x_rd_step, y_rd_step;
  logic [15:0] x_wr_step, x_rd_data, y_rd_data, x_rd_next, y_rd_next;
  logic [15:0] x_wr_next, v;
  logic [15:0] mem [int];
  int          num_errors, check_count;

  dxyds_core u_dxyds_core (
    .mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mac_op, .x_rd_en, .x_rd_ea, .x_rd_byte,
    .x_rd_step, .y_rd_en, .y_rd_ea, .y_rd_step, .x_wr_en, .x_wr_ea,
    .x_wr_byte, .x_wr_data, .x_wr_step, .x_wr_brev, .x_rd_data,
    .x_rd_valid, .y_rd_data, .y_rd_valid, .x_rd_next, .y_rd_next,
    .x_wr_next, .addr_err
  );
  dxyds_exec_model u_dxyds_exec_model (
    .mclk, .mac_op, .x_rd_en, .y_rd_en, .x_wr_en, .x_rd_byte, .x_wr_byte,
    .x_wr_brev, .x_rd_ea, .y_rd_ea, .x_wr_ea, .x_wr_data, .x_rd_step,
    .y_rd_step, .x_wr_step
  );
  ////////////////////////////////////////
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    report_and_stop();
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected word at a data address
  function automatic logic [15:0] xexp(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 16'h0000;
  endfunction

  // One APB transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [15:0] idx, wd);
    @(posedge mclk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr  <= {idx, 2'b00};
    pwdata <= {16'($urandom), wd};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // Core write through the X write path, model updated by lane
  task automatic cwr(input logic [15:0] a, d, input logic [1:0] fl);
    logic [15:0] w;
    w = xexp({a[15:1], 1'b0});
    u_dxyds_exec_model.op(0, 0, 0, 1, 0, 0, a, d, 16'h0002, fl);
    #1;
    chk("addr err", {31'h0, !fl[0] && a[0]}, {31'h0, addr_err});
    if (!fl[1]) chk("x write next", 16'(a + 16'h0002), x_wr_next);
    if (fl[0] && a[0]) w[15:8] = d[7:0];
    else if (fl[0]) w[7:0] = d[7:0];
    else if (!a[0]) w = d;
    if (a < 16'h0030 || (a >= RAM_BASE && a <= RAM_LAST))
      mem[{a[15:1], 1'b0}] = w;
  endtask

  // Dual operand read on X and Y together
  task automatic crd(input logic [15:0] xa, ya, st, xn, yn);
    u_dxyds_exec_model.op(1, 1, 1, 0, xa, ya, 0, 0, st, 2'b00);
    #1;
    chk("x valid", 1, x_rd_valid);
    chk("y valid", 1, y_rd_valid);
    chk("x data", xexp(xa), x_rd_data);
    chk("y data", (ya >= Y_BASE && ya <= RAM_LAST) ? xexp(ya) : 0,
        y_rd_data);
    chk("x next", xn, x_rd_next);
    chk("y next", yn, y_rd_next);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 53'h0};
    void'($urandom(32'h60ff));
    for (int i = 0; i < NREG; i++) mem[2*i] = (i == 15) ? 16'h0800 : 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < NREG; i++) begin
      apb(1'b0, REG_OFS[i], 0);
      if (i != SLOT_LIMIT) chk("reset value", mem[2*i], rd);
    end
    $display("test reset values done");
    for (int i = 0; i < NREG; i++) begin
      v = 16'($urandom);
      apb(1'b1, REG_OFS[i], v);
      mem[2*i] = v;
    end
    for (int i = 0; i < NREG; i++) begin
      apb(1'b0, REG_OFS[i], 0);
      chk("reg readback", mem[2*i], rd);
    end
    apb(1'b0, 16'h0001, 0);
    chk("unused data", 0, rd);
    chk("unused err", 1, er);
    $display("test registers done");
    for (int i = 0; i < NREG; i++) begin
      cwr(Y_BASE + 16'(2*i), 16'($urandom), 2'b00);
      crd(16'(2*i), Y_BASE + 16'(2*i), 2, 16'(2*i+2), Y_BASE + 16'(2*i+2));
    end
    cwr(16'h0006, 16'($urandom), 2'b00);
    cwr(16'h0007, 16'h00a5, 2'b01);
    cwr(16'h0007, 16'hffff, 2'b00);
    apb(1'b0, REG_OFS[3], 0);
    chk("core written reg", mem[6], rd);
    u_dxyds_exec_model.op(0, 1, 1, 0, 0, 16'h0c00, 0, 0, 2, 2'b00);
    #1;
    chk("y without mac", 0, y_rd_valid);
    crd(16'hfffe, 16'h1000, 2, 16'h0000, 16'h1002);
    $display("test core paths done");
    cwr(16'h0806, 16'($urandom), 2'b00);
    cwr(16'h0800, 16'($urandom), 2'b00);
    apb(1'b1, OFS_CFG, 16'h0003);
    apb(1'b1, OFS_XMS, 16'h0800);
    apb(1'b1, OFS_XME, 16'h0807);
    apb(1'b1, OFS_YMS, 16'h0c00);
    apb(1'b1, OFS_YME, 16'h0c07);
    crd(16'h0806, 16'h0c06, 2, 16'h0800, 16'h0c00);
    crd(16'h0800, 16'h0c00, 16'hfffe, 16'h0806, 16'h0c06);
    apb(1'b1, OFS_CFG, 16'h0004);
    apb(1'b1, OFS_BMOD, 16'h0008);
    crd(16'h0800, 16'h0c00, 2, 16'h0802, 16'h0c02);
    // Reverse-carry step of 4 words from word index 0x400
    cwr(16'h0800, 16'($urandom), 2'b10);
    chk("x write brev next", 16'h0808, x_wr_next);
    cwr(16'h0100, 16'($urandom), 2'b00);
    crd(16'h0100, 16'h0bfe, 2, 16'h0102, 16'h0c00);
    $display("test addressing modes done");
    report_and_stop();
  end
endmodule // dxyds_core_tb_top

// ===== tb/dxyds_exec_model.sv
/*
  Execution unit model: drives the core request ports of the block.
  Assumes requests launch just after a rising mclk edge.
*/
`timescale 1ns/1ps
module dxyds_exec_model
  import dxyds_pkg::*;
(
  input  wire logic        mclk,
  output logic             mac_op,
  output logic             x_rd_en,
  output logic             y_rd_en,
  output logic             x_wr_en,
  output logic             x_rd_byte,
  output logic             x_wr_byte,
  output logic             x_wr_brev,
  output logic      [15:0] x_rd_ea,
  output logic      [15:0] y_rd_ea,
  output logic      [15:0] x_wr_ea,
  output logic      [15:0] x_wr_data,
  output logic      [15:0] x_rd_step,
  output logic      [15:0] y_rd_step,
  output logic      [15:0] x_wr_step
);
  ////////////////////////////////////////
  // Idle levels at time zero
  initial begin
    {mac_op, x_rd_en, y_rd_en, x_wr_en, x_rd_byte, x_wr_byte} = '0;
    {x_wr_brev, x_rd_ea, y_rd_ea, x_wr_ea, x_wr_data} = '0;
    {x_rd_step, y_rd_step, x_wr_step} = '0;
  end

  // One request cycle; enables then drop, addresses and write data show their inverse
  task automatic op(input logic m, xr, yr, w,
                    input logic [15:0] xa, ya, wa, wd, st,
                    input logic [1:0] fl);
    @(posedge mclk);
    mac_op    <= m;
    x_rd_en   <= xr;
    y_rd_en   <= yr;
    x_wr_en   <= w;
    x_rd_byte <= fl[0];
    x_wr_byte <= fl[0];
    x_wr_brev <= fl[1];
    x_rd_ea   <= xa;
    y_rd_ea   <= ya;
    x_wr_ea   <= wa;
    x_wr_data <= wd;
    x_rd_step <= st;
    y_rd_step <= st;
    x_wr_step <= st;
    @(posedge mclk);
    {mac_op, x_rd_en, y_rd_en, x_wr_en} <= '0;
    x_rd_ea   <= ~xa;
    y_rd_ea   <= ~ya;
    x_wr_ea   <= ~wa;
    x_wr_data <= ~wd;
  endtask
endmodule // dxyds_exec_model
